// >>> otb_trace_unit.sv
// Debug trace unit: comparators, trace FIFO, control register, host force reset
//
// Contract
// - Forced-reset register writes accepted only from serial debug commands, CPU writes ignored.
// - Forced-reset register always reads as zero.
// - Host writing one to force reset bit resets the whole MCU.
// - Two 16-bit comparators in four byte registers, reset to zero, always readable.
// - Comparator byte registers cannot be written while armed.
// - FIFO high port read-only; reads zero in event-only modes.
// - Reading FIFO high port never advances the FIFO.
// - FIFO low read returns low byte then advances; writes ignored.
// - Event-only modes store 8-bit data in low half of each word.
// - Low reads while armed do not advance FIFO; reader waits for run end.
// - Low read while disarmed stores latest opcode address into last FIFO slot.
// - Disarmed FIFO is eight-deep delay line; ninth read returns first capture.
// - Enable bit 7 turns unit on; cannot be set while secured.
// - Arm bit 6 set by write, cleared at run end or by zero write.
// - Bit 5 selects force (0) or tag (1) break; ignored when breaks disabled.
// - Bit 4 lets triggers request a break; otherwise triggers only store.
// - End trace breaks at trigger; begin trace breaks when FIFO becomes full.
// - Comparator A direction enable bit 2, value bit 3 (0 write, 1 read).
// - Comparator B direction enable bit 0, value bit 1 (0 write, 1 read).
// - Control register readable and writable at all times, even armed.
// - Eight bytes of registers reachable from ordinary application code.
// - Run ends on FIFO full in begin trace or trigger in end trace.
// - Armed status flag mirrors arm bit while enabled.
`timescale 1ns/10ps
`default_nettype none

module otb_trace_unit #(
  parameter int FIFO_DEPTH = 8,
  parameter int ADDR_W     = 16
) (
  input  wire logic                         clk_in,
  input  wire logic                         sys_rst_in,
  input  wire logic [otb_pkg::REG_IDX_W-1:0] reg_idx_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic [otb_pkg::BYTE_W-1:0]   reg_wdata_in,
  input  wire logic                         host_cmd_in,
  input  wire logic                         secure_in,
  input  wire logic [3:0]                   trig_mode_in,
  input  wire logic                         trace_begin_in,
  input  wire logic                         trigger_qualify_select_in,
  input  wire logic                         opcode_exec_in,
  input  wire logic                         bus_valid_in,
  input  wire logic                         bus_rw_in,
  input  wire logic [ADDR_W-1:0]            bus_addr_in,
  input  wire logic [otb_pkg::BYTE_W-1:0]   bus_data_in,
  input  wire logic                         cof_valid_in,
  input  wire logic [ADDR_W-1:0]            cof_addr_in,
  input  wire logic [ADDR_W-1:0]            opcode_addr_in,
  output logic      [otb_pkg::BYTE_W-1:0]   reg_rdata_out,
  output logic                              brk_req_out,
  output logic                              brk_tag_out,
  output logic                              mcu_reset_out,
  output logic                              armed_status_flag_out,
  output logic      [3:0]                   fifo_count_out
);
  import otb_pkg::*;

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int LAST  = FIFO_DEPTH - 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  // State registers
  logic [BYTE_W-1:0]  cmp_a_high_ff;
  logic [BYTE_W-1:0]  cmp_a_low_ff;
  logic [BYTE_W-1:0]  cmp_b_high_ff;
  logic [BYTE_W-1:0]  cmp_b_low_ff;
  logic               enable_ff;
  logic               tag_ff;
  logic               break_request_enable_ff;
  logic [3:0]         dir_ff;
  otb_run_state_t     state_ff;
  otb_run_state_t     nxt_state;
  logic               a_seen_ff;
  logic [CNT_W-1:0]   cnt_ff;
  logic [ADDR_W-1:0]  fifo_ff [FIFO_DEPTH];
  logic [BYTE_W-1:0]  rdata_ff;
  logic               brk_req_ff;
  logic               brk_tag_ff;
  logic               rst_pulse_ff;
  logic               armed_ff;

  // Register decode
  wire armed_w  = (state_ff != OTB_ST_IDLE);
  wire wr_ctl   = reg_wr_in && (reg_idx_in == IDX_CONTROL);
  wire wr_cmp   = reg_wr_in && !armed_w;
  wire rd_low   = reg_rd_in && (reg_idx_in == IDX_FIFO_LOW);
  wire evt_mode = (trig_mode_in == TRG_EVENT_B) || (trig_mode_in == TRG_A_THEN_EVT_B);
  wire begin_tr = trace_begin_in || evt_mode;

  // Control write fields
  wire nxt_enable = reg_wdata_in[CTL_ENABLE_BIT] && !secure_in;
  wire arm_req    = reg_wdata_in[CTL_ARM_BIT] && nxt_enable;
  wire start_run  = wr_ctl && arm_req && !armed_w;
  wire stop_run   = (wr_ctl && !arm_req) || !enable_ff;

  // Comparator values and direction qualification
  wire [ADDR_W-1:0] cmp_a = {cmp_a_high_ff, cmp_a_low_ff};
  wire [ADDR_W-1:0] cmp_b = {cmp_b_high_ff, cmp_b_low_ff};
  wire dir_ok_a = !dir_ff[CTL_CMP_A_DIR_ENABLE_BIT] || (bus_rw_in == dir_ff[CTL_RWA_BIT]);
  wire dir_ok_b = !dir_ff[CTL_CMP_B_DIR_ENABLE_BIT] || (bus_rw_in == dir_ff[CTL_RWB_BIT]);
  wire cmp_on   = bus_valid_in && armed_w && enable_ff;
  wire hit_a    = cmp_on && dir_ok_a && (bus_addr_in == cmp_a);
  wire hit_b    = cmp_on && dir_ok_b && (bus_addr_in == cmp_b);
  wire data_b   = cmp_on && dir_ok_b && (bus_data_in == cmp_b_low_ff);
  wire in_rng   = (bus_addr_in >= cmp_a) && (bus_addr_in <= cmp_b);

  // Trigger selection by mode
  logic raw_hit;
  always_comb begin
    case (trig_mode_in)
      TRG_A_ONLY:       raw_hit = hit_a;
      TRG_A_OR_B:       raw_hit = hit_a || hit_b;
      TRG_A_THEN_B:     raw_hit = a_seen_ff && hit_b;
      TRG_EVENT_B:      raw_hit = hit_b;
      TRG_A_THEN_EVT_B: raw_hit = a_seen_ff && hit_b;
      TRG_A_AND_B_DATA: raw_hit = hit_a && data_b;
      TRG_A_NOT_B_DATA: raw_hit = hit_a && !data_b;
      TRG_INSIDE_RANGE: raw_hit = cmp_on && in_rng;
      TRG_OUTSIDE_RNG:  raw_hit = cmp_on && !in_rng;
      default:          raw_hit = 1'b0;
    endcase
  end

  // Optional opcode qualification of the trigger
  wire trig_hit = raw_hit && (!trigger_qualify_select_in || opcode_exec_in);

  // Storage requests
  wire push_evt  = evt_mode && (state_ff == OTB_ST_WAIT) && trig_hit;
  wire push_end  = !begin_tr && (state_ff == OTB_ST_WAIT) && cof_valid_in;
  wire push_beg  = !evt_mode && (state_ff == OTB_ST_CAPTURE) && cof_valid_in;
  wire push      = (push_evt || push_end || push_beg) && enable_ff && !stop_run;
  wire push_full = push && (cnt_ff == CNT_FULL - CNT_ONE);
  wire prof_shift = rd_low && !armed_w;
  wire shift_en  = push || prof_shift;
  wire [ADDR_W-1:0] push_data = push_evt ? {BYTE_ZERO, bus_data_in} : cof_addr_in;
  wire [ADDR_W-1:0] shift_data = prof_shift ? opcode_addr_in : push_data;

  // Run end conditions
  wire end_trig = !begin_tr && (state_ff == OTB_ST_WAIT) && trig_hit;
  wire end_full = begin_tr && push_full;
  wire run_end  = end_trig || end_full;
  wire nxt_brk  = run_end && break_request_enable_ff && !stop_run;

  // Run state transitions
  always_comb begin
    case (state_ff)
      OTB_ST_IDLE: begin
        nxt_state = start_run ? OTB_ST_WAIT : OTB_ST_IDLE;
      end
      OTB_ST_WAIT: begin
        if (stop_run || run_end) begin
          nxt_state = OTB_ST_IDLE;
        end else if (trace_begin_in && !evt_mode && trig_hit) begin
          nxt_state = OTB_ST_CAPTURE;
        end else begin
          nxt_state = OTB_ST_WAIT;
        end
      end
      OTB_ST_CAPTURE: begin
        nxt_state = (stop_run || run_end) ? OTB_ST_IDLE : OTB_ST_CAPTURE;
      end
      default: nxt_state = OTB_ST_IDLE;
    endcase
  end

  // Read data selection
  logic [BYTE_W-1:0] rd_mux;
  always_comb begin
    case (reg_idx_in)
      IDX_CMP_A_HIGH: rd_mux = cmp_a_high_ff;
      IDX_CMP_A_LOW:  rd_mux = cmp_a_low_ff;
      IDX_CMP_B_HIGH: rd_mux = cmp_b_high_ff;
      IDX_CMP_B_LOW:  rd_mux = cmp_b_low_ff;
      IDX_FIFO_HIGH:  rd_mux = evt_mode ? BYTE_ZERO : fifo_ff[0][ADDR_W-1:BYTE_W];
      IDX_FIFO_LOW:   rd_mux = fifo_ff[0][BYTE_W-1:0];
      IDX_CONTROL:    rd_mux = {enable_ff, armed_w, tag_ff, break_request_enable_ff, dir_ff};
      IDX_FORCE_RST:  rd_mux = BYTE_ZERO;
      default:        rd_mux = BYTE_ZERO;
    endcase
  end

  // Comparator byte registers, locked while armed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmp_a_high_ff <= BYTE_ZERO;
      cmp_a_low_ff  <= BYTE_ZERO;
      cmp_b_high_ff <= BYTE_ZERO;
      cmp_b_low_ff  <= BYTE_ZERO;
    end else if (wr_cmp) begin
      if (reg_idx_in == IDX_CMP_A_HIGH) cmp_a_high_ff <= reg_wdata_in;
      if (reg_idx_in == IDX_CMP_A_LOW)  cmp_a_low_ff  <= reg_wdata_in;
      if (reg_idx_in == IDX_CMP_B_HIGH) cmp_b_high_ff <= reg_wdata_in;
      if (reg_idx_in == IDX_CMP_B_LOW)  cmp_b_low_ff  <= reg_wdata_in;
    end
  end

  // Control register fields
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_ff <= BIT_ZERO;
      tag_ff    <= BIT_ZERO;
      break_request_enable_ff  <= BIT_ZERO;
      dir_ff    <= 4'h0;
    end else if (wr_ctl) begin
      enable_ff <= nxt_enable;
      tag_ff    <= reg_wdata_in[CTL_TAG_BIT];
      break_request_enable_ff  <= reg_wdata_in[CTL_BREAK_REQUEST_ENABLE_BIT];
      dir_ff    <= reg_wdata_in[CTL_RWA_BIT:CTL_CMP_B_DIR_ENABLE_BIT];
    end
  end

  // Run state and sequence tracking
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff  <= OTB_ST_IDLE;
      a_seen_ff <= BIT_ZERO;
      armed_ff  <= BIT_ZERO;
    end else begin
      state_ff  <= nxt_state;
      a_seen_ff <= start_run ? BIT_ZERO : (a_seen_ff || hit_a);
      armed_ff  <= (nxt_state != OTB_ST_IDLE);
    end
  end

  // Valid word count, cleared at arming, saturating at depth
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= CNT_ZERO;
    end else if (start_run) begin
      cnt_ff <= CNT_ZERO;
    end else if (push && (cnt_ff != CNT_FULL)) begin
      cnt_ff <= cnt_ff + CNT_ONE;
    end
  end

  // Trace FIFO as shift chain: head at 0, new words enter at the last slot
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          fifo_ff[gi] <= {ADDR_W{1'b0}};
        end else if (shift_en) begin
          fifo_ff[gi] <= (gi == LAST) ? shift_data : fifo_ff[(gi == LAST) ? gi : gi + 1];
        end
      end
    end
  endgenerate

  // Read data, break request and host reset outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_ff     <= BYTE_ZERO;
      brk_req_ff   <= BIT_ZERO;
      brk_tag_ff   <= BIT_ZERO;
      rst_pulse_ff <= BIT_ZERO;
    end else begin
      if (reg_rd_in) rdata_ff <= rd_mux;
      brk_req_ff   <= nxt_brk;
      brk_tag_ff   <= nxt_brk ? tag_ff : brk_tag_ff;
      rst_pulse_ff <= reg_wr_in && host_cmd_in && (reg_idx_in == IDX_FORCE_RST)
                      && reg_wdata_in[HOST_FORCE_RESET_BIT];
    end
  end

  // Output drive
  assign reg_rdata_out         = rdata_ff;
  assign brk_req_out           = brk_req_ff;
  assign brk_tag_out           = brk_tag_ff;
  assign mcu_reset_out         = rst_pulse_ff;
  assign armed_status_flag_out = armed_ff;
  assign fifo_count_out        = 4'(cnt_ff);

  // Checks
  sequence s_arm_write;
    wr_ctl && arm_req && !armed_w;
  endsequence

  sequence s_cpu_reset_write;
    reg_wr_in && !host_cmd_in && (reg_idx_in == IDX_FORCE_RST);
  endsequence

  chk_cpu_reset_ignored: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_cpu_reset_write |=> !mcu_reset_out)
    else $error("CPU write reached the forced reset");

  chk_host_reset_forced: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && host_cmd_in && (reg_idx_in == IDX_FORCE_RST)
     && reg_wdata_in[HOST_FORCE_RESET_BIT]) |=> mcu_reset_out ##1 !mcu_reset_out)
    else $error("Host force reset not a one cycle pulse");

  chk_reset_reads_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (reg_rd_in && (reg_idx_in == IDX_FORCE_RST)) |=> (reg_rdata_out == BYTE_ZERO))
    else $error("Forced reset register read nonzero");

  chk_cmp_armed_lock: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    armed_w |=> ($stable(cmp_a_high_ff) && $stable(cmp_a_low_ff)
                 && $stable(cmp_b_high_ff) && $stable(cmp_b_low_ff)))
    else $error("Comparator changed while armed");

  chk_high_no_advance: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (reg_rd_in && (reg_idx_in == IDX_FIFO_HIGH) && !armed_w) |=> $stable(fifo_ff[0]))
    else $error("FIFO high read moved the FIFO");

  chk_event_high_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (reg_rd_in && (reg_idx_in == IDX_FIFO_HIGH) && evt_mode) |=> (reg_rdata_out == BYTE_ZERO))
    else $error("FIFO high nonzero in event mode");

  chk_profile_capture: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (rd_low && !armed_w) |=> (fifo_ff[LAST] == $past(opcode_addr_in)))
    else $error("Profile read did not store opcode address");

  chk_secure_enable: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_ctl && secure_in) |=> !enable_ff)
    else $error("Enable set while secured");

  chk_arm_sets_flag: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_arm_write |=> armed_status_flag_out)
    else $error("Arm write did not set armed flag");

  chk_disabled_quiet: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (!enable_ff && !wr_ctl) |=> (!brk_req_out && !armed_status_flag_out))
    else $error("Disabled unit broke or stayed armed");

  chk_break_cause: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    brk_req_out |-> ($past(break_request_enable_ff) && $past(armed_w) && !armed_status_flag_out))
    else $error("Break without enable or run end");

  chk_event_low_byte: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (push && push_evt) |=> (fifo_ff[LAST] == {BYTE_ZERO, $past(bus_data_in)}))
    else $error("Event word not stored as low byte");

  chk_break_tag_kind: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    brk_req_out |-> (brk_tag_out == $past(tag_ff)))
    else $error("Break kind differs from tag select");

  chk_write_no_shift: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && !reg_rd_in && !armed_w) |=> $stable(fifo_ff[0]))
    else $error("Register write moved the FIFO");

  chk_armed_no_shift: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (rd_low && armed_w && !push) |=> $stable(fifo_ff[0]))
    else $error("Armed low read moved the FIFO");

  chk_full_ends_run: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    end_full |=> !armed_status_flag_out)
    else $error("Full FIFO did not end the run");

endmodule

`default_nettype wire

// >>> otb_pkg.sv
// Shared constants for the on-chip trace and breakpoint register block
package otb_pkg;

  // Register index width and byte width of the CPU register port
  localparam int REG_IDX_W = 4;
  localparam int BYTE_W    = 8;

  // Register indices within the debug register window
  localparam logic [REG_IDX_W-1:0] IDX_CMP_A_HIGH = 4'h0;
  localparam logic [REG_IDX_W-1:0] IDX_CMP_A_LOW  = 4'h1;
  localparam logic [REG_IDX_W-1:0] IDX_CMP_B_HIGH = 4'h2;
  localparam logic [REG_IDX_W-1:0] IDX_CMP_B_LOW  = 4'h3;
  localparam logic [REG_IDX_W-1:0] IDX_FIFO_HIGH  = 4'h4;
  localparam logic [REG_IDX_W-1:0] IDX_FIFO_LOW   = 4'h5;
  localparam logic [REG_IDX_W-1:0] IDX_CONTROL    = 4'h6;
  localparam logic [REG_IDX_W-1:0] IDX_FORCE_RST  = 4'hF;

  // Control register field positions
  localparam int CTL_ENABLE_BIT  = 7;
  localparam int CTL_ARM_BIT     = 6;
  localparam int CTL_TAG_BIT     = 5;
  localparam int CTL_BREAK_REQUEST_ENABLE_BIT   = 4;
  localparam int CTL_RWA_BIT     = 3;
  localparam int CTL_CMP_A_DIR_ENABLE_BIT   = 2;
  localparam int CTL_RWB_BIT     = 1;
  localparam int CTL_CMP_B_DIR_ENABLE_BIT   = 0;

  // Host force reset bit position
  localparam int HOST_FORCE_RESET_BIT = 0;

  // Reset and read-as-zero values
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic              BIT_ZERO  = 1'h0;

  // Trigger mode encodings
  localparam logic [3:0] TRG_A_ONLY       = 4'h0;
  localparam logic [3:0] TRG_A_OR_B       = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B     = 4'h2;
  localparam logic [3:0] TRG_EVENT_B      = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVT_B = 4'h4;
  localparam logic [3:0] TRG_A_AND_B_DATA = 4'h5;
  localparam logic [3:0] TRG_A_NOT_B_DATA = 4'h6;
  localparam logic [3:0] TRG_INSIDE_RANGE = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE_RNG  = 4'h8;

  // Run state of the trace unit
  typedef enum logic [2:0] {
    OTB_ST_IDLE    = 3'b001,
    OTB_ST_WAIT    = 3'b010,
    OTB_ST_CAPTURE = 3'b100
  } otb_run_state_t;

endpackage

// >>> otb_cpu_model.sv
// CPU core bus model facing the trace unit
`timescale 1ns/10ps
`default_nettype none

module otb_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        acc_go_in,
  input  wire logic        acc_rw_in,
  input  wire logic [15:0] acc_addr_in,
  output logic             bus_valid_out,
  output logic             bus_rw_out,
  output logic [15:0]      bus_addr_out,
  output logic [7:0]       bus_data_out,
  output logic [15:0]      opcode_addr_out
);
  logic [15:0] last_ff = 16'h0000;
  logic [15:0] pc_ff   = 16'h1000;

  // Access lines; idle bus shows the inverse of the last address
  assign bus_valid_out   = acc_go_in;
  assign bus_rw_out      = acc_go_in ? acc_rw_in : ~last_ff[0];
  assign bus_addr_out    = acc_go_in ? acc_addr_in : ~last_ff;
  assign bus_data_out    = acc_go_in ? 8'hA5 : ~last_ff[7:0];
  assign opcode_addr_out = pc_ff;

  // Fetch address moves on every cycle, off the sampling edge
  always @(negedge clk_in) begin
    pc_ff <= pc_ff + 16'h0111;
  end

  // Remember the last address put on the bus
  always @(posedge clk_in) begin
    if (acc_go_in) begin
      last_ff <= acc_addr_in;
    end
  end
endmodule

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the trace unit register block
`timescale 1ns/10ps
`default_nettype none

module tb;
  import otb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, host = 1'b0;
  logic sec = 1'b0, go = 1'b0, arw = 1'b0;
  logic [3:0] idx = 4'h0, trig = 4'h0;
  logic [7:0] wd = 8'h00, rdat, hi_a, hi_b;
  logic [15:0] aaddr = 16'h0000;
  logic [15:0] capq[$];
  wire bv, brw, brk, tag, mrst, armed_status_flag;
  wire [15:0] baddr, opc;
  wire [7:0] bdat, rdata;
  wire [3:0] cnt;
  int n_mismatch = 0, n_checks = 0;

  // Clock at 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  otb_trace_unit dut (.clk_in(clk), .sys_rst_in(rst), .reg_idx_in(idx),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .host_cmd_in(host),
    .secure_in(sec), .trig_mode_in(trig), .trace_begin_in(1'b0),
    .trigger_qualify_select_in(1'b0), .opcode_exec_in(1'b1),
    .bus_valid_in(bv), .bus_rw_in(brw), .bus_addr_in(baddr),
    .bus_data_in(bdat), .cof_valid_in(1'b0), .cof_addr_in(16'h0000),
    .opcode_addr_in(opc), .reg_rdata_out(rdata), .brk_req_out(brk),
    .brk_tag_out(tag), .mcu_reset_out(mrst),
    .armed_status_flag_out(armed_status_flag), .fifo_count_out(cnt));

  otb_cpu_model cpu (.clk_in(clk), .acc_go_in(go), .acc_rw_in(arw),
    .acc_addr_in(aaddr), .bus_valid_out(bv), .bus_rw_out(brw),
    .bus_addr_out(baddr), .bus_data_out(bdat), .opcode_addr_out(opc));

  // Byte and flag comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask

  // One-cycle register write and read strobes
  task automatic wreg(input logic [3:0] i, input logic [7:0] d, input logic h);
    @(negedge clk);
    idx = i; wd = d; host = h; wr = 1'b1;
    @(negedge clk);
    wr = 1'b0; host = 1'b0;
  endtask
  task automatic rreg(input logic [3:0] i);
    @(negedge clk);
    idx = i; rd = 1'b1;
    @(posedge clk);
    if (i == IDX_FIFO_LOW) capq.push_back(opc);
    @(negedge clk);
    rd = 1'b0; rdat = rdata;
  endtask

  // CPU bus access for one cycle, then a bounded look for a break
  task automatic acc(input logic r, input logic [15:0] a, input logic exp);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    go = 1'b1; arw = r; aaddr = a;
    @(negedge clk);
    go = 1'b0;
    seen = (brk === 1'b1);
    repeat (4) begin
      @(negedge clk);
      seen = seen | (brk === 1'b1);
    end
    chk1(seen, exp);
  endtask

  // Reset values of comparator and control reads
  task automatic t_reset_vals();
    for (int i = 0; i < 4; i++) begin
      rreg(4'(i));
      chk8(rdat, BYTE_ZERO);
    end
    rreg(IDX_CONTROL);
    chk8(rdat, BYTE_ZERO);
  endtask

  // Forced reset from CPU ignored, from host honoured, reads zero
  task automatic t_force_rst();
    wreg(IDX_FORCE_RST, 8'h01, 1'b0);
    chk1(mrst, 1'b0);
    wreg(IDX_FORCE_RST, 8'h01, 1'b1);
    chk1(mrst, 1'b1);
    rreg(IDX_FORCE_RST);
    chk8(rdat, BYTE_ZERO);
    chk1(mrst, 1'b0);
  endtask

  // Disarmed profiling: ninth word is the first capture
  task automatic t_profile();
    wreg(IDX_FIFO_LOW, 8'h3C, 1'b0);
    capq.delete();
    repeat (8) begin
      rreg(IDX_FIFO_HIGH);
      rreg(IDX_FIFO_LOW);
    end
    rreg(IDX_FIFO_HIGH);
    hi_a = rdat;
    rreg(IDX_FIFO_HIGH);
    hi_b = rdat;
    chk8(hi_b, hi_a);
    chk8(hi_a, capq[0][15:8]);
    rreg(IDX_FIFO_LOW);
    chk8(rdat, capq[0][7:0]);
    rreg(IDX_FIFO_LOW);
    chk8(rdat, capq[1][7:0]);
  endtask

  // Secured part refuses the enable bit
  task automatic t_secure();
    sec = 1'b1;
    wreg(IDX_CONTROL, 8'h80, 1'b0);
    rreg(IDX_CONTROL);
    chk1(rdat[CTL_ENABLE_BIT], 1'b0);
    sec = 1'b0;
  endtask

  // Armed without trigger: locked comparators, open control, manual stop
  task automatic t_arm_lock();
    trig = 4'h9;
    wreg(IDX_CONTROL, 8'hD0, 1'b0);
    chk1(armed_status_flag, 1'b1);
    wreg(IDX_CMP_A_HIGH, 8'h77, 1'b0);
    rreg(IDX_CMP_A_HIGH);
    chk8(rdat, BYTE_ZERO);
    rreg(IDX_CONTROL);
    chk8(rdat, 8'hD0);
    rreg(IDX_FIFO_LOW);
    hi_a = rdat;
    rreg(IDX_FIFO_LOW);
    chk8(rdat, hi_a);
    acc(1'b1, 16'h0000, 1'b0);
    wreg(IDX_CONTROL, 8'h80, 1'b0);
    chk1(armed_status_flag, 1'b0);
    trig = TRG_A_ONLY;
  endtask

  // End trace on A: direction filter, force break, run end
  task automatic t_break();
    wreg(IDX_CMP_A_HIGH, 8'h12, 1'b0);
    wreg(IDX_CMP_A_LOW, 8'h34, 1'b0);
    rreg(IDX_CMP_A_LOW);
    chk8(rdat, 8'h34);
    wreg(IDX_CONTROL, 8'hDC, 1'b0);
    acc(1'b0, 16'h1234, 1'b0);
    acc(1'b1, 16'h1234, 1'b1);
    chk1(tag, 1'b0);
    chk1(armed_status_flag, 1'b0);
    wreg(IDX_CONTROL, 8'hC0, 1'b0);
    acc(1'b1, 16'h1234, 1'b0);
    wreg(IDX_CONTROL, 8'h40, 1'b0);
    acc(1'b1, 16'h1234, 1'b0);
    wreg(IDX_CONTROL, 8'hF0, 1'b0);
    acc(1'b0, 16'h1234, 1'b1);
    chk1(tag, 1'b1);
  endtask

  // Event-only B run: direction filter, byte storage, full FIFO ends run
  task automatic t_event();
    trig = TRG_EVENT_B;
    rreg(IDX_FIFO_HIGH);
    chk8(rdat, BYTE_ZERO);
    wreg(IDX_CMP_B_HIGH, 8'h20, 1'b0);
    wreg(IDX_CMP_B_LOW, 8'h40, 1'b0);
    wreg(IDX_CONTROL, 8'hD1, 1'b0);
    acc(1'b1, 16'h2040, 1'b0);
    repeat (7) begin
      acc(1'b0, 16'h2040, 1'b0);
    end
    acc(1'b0, 16'h2040, 1'b1);
    chk8({4'h0, cnt}, 8'h08);
    chk1(armed_status_flag, 1'b0);
    rreg(IDX_FIFO_LOW);
    chk8(rdat, 8'hA5);
    trig = 4'h9;
    rreg(IDX_FIFO_HIGH);
    chk8(rdat, BYTE_ZERO);
    trig = TRG_A_ONLY;
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset_vals();
    t_force_rst();
    t_profile();
    t_secure();
    t_arm_lock();
    t_break();
    t_event();
    complete_run();
  end
endmodule

`default_nettype wire
